// ---- design/pump_supervisor_pkg.sv ----
// Behaviour
// - Units digit of the channel setting picks analog input; zero disables analog level.
// - Tens digit sets polarity: zero means 100 percent is full, one reverses.
// - Any closed digital input assigned function 60 means full water, always.
// - Analog full: level above threshold (positive) or below it (inverse).
// - Full condition held unbroken for detect time raises full alarm and stops pump.
// - Full alarm clears once no full condition held longer than recovery time.
// - Running with power below nonzero threshold for detect time raises power alarm.
// - Low-power stop ends after condition absent for its recovery delay.
// - Running with current above threshold for detect time raises same power alarm.
// - Overcurrent stop ends after condition absent for its recovery delay.
// - Daily volume counts in 0.1 cubic metre, cleared at power loss.
// - Cumulative 32-bit volume in cubic metres resumes from the saved value.
// - Writing one clears cumulative volume; the request drops back to zero itself.
// - Power tracker samples and adjusts every 2 ms; larger step converges faster.
// - Voltage regulator uses proportional and integral gains in 0.001 units.
// - Flow estimate is rated flow scaled by output over reference frequency.
// - Start voltage is the start ratio times the open-circuit voltage.
// - Fast-function units digit enables fast start, tens digit fast tracking.
// - Tracking step is the bus voltage reference change per tracking cycle.
package pump_supervisor_pkg;

  // Clock and tick timing
  localparam int CLK_HZ           = 10_000_000;
  localparam int TICK_TIME_MS     = 100;
  localparam int TICK_CYCLES      = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int MPPT_PERIOD_US   = 2000;
  localparam int MPPT_CYCLES      = CLK_HZ / 1_000_000 * MPPT_PERIOD_US;

  // Digit fields of the channel and fast-function settings
  localparam int UNITS_LSB        = 0;
  localparam int TENS_LSB         = 4;
  localparam int DIGIT_W          = 4;
  localparam logic [3:0] DIGIT_OFF = 4'h0;

  // Digital input function code meaning full water
  localparam logic [7:0] FULL_SWITCH_FUNC = 8'h3c;

  // Volume scaling: 0.1 m3/h over a 0.1 s tick, and tenths per cubic metre
  localparam logic [16:0] VOLUME_TICKS_PER_TENTH = 17'h08ca0;
  localparam logic [3:0]  TENTHS_PER_M3          = 4'ha;

  // Gains and ratios are in thousandths
  localparam int UNIT_SCALE       = 1000;

  // Reset values
  localparam logic [11:0] VREF_RESET = 12'h000;

  typedef struct packed {
    logic [15:0] detect_time;   // 0.1 s units
    logic [15:0] recover_time;  // 0.1 s units
  } timer_setting_type;

  typedef struct packed {
    logic overcurrent;
    logic low_power;
    logic full_water;
  } alarm_type;

  typedef enum logic {
    PS_NORMAL = 1'b0,
    PS_ALARM  = 1'b1
  } prot_state_type;

  typedef enum logic [1:0] {
    MP_IDLE  = 2'b00,
    MP_START = 2'b01,
    MP_TRACK = 2'b11
  } mppt_state_type;

endpackage

// ---- design/pump_protection_supervisor.sv ----
`timescale 1ns/100ps
module pump_protection_supervisor import pump_supervisor_pkg::*; #(
  parameter int N_DI        = 6,
  parameter int N_AI        = 4,
  parameter int TICK_DIV    = TICK_CYCLES,
  parameter int MPPT_DIV    = MPPT_CYCLES
) (
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  input  wire logic                          running,
  input  wire logic [N_DI-1:0]               di_closed,
  input  wire logic [N_DI-1:0][7:0]          di_function,
  input  wire logic [N_AI-1:0][9:0]          analog_level,
  input  wire logic [7:0]                    full_level_channel_select,
  input  wire logic [9:0]                    full_level_threshold,
  input  wire timer_setting_type             full_level_timing,
  input  wire timer_setting_type             low_power_timing,
  input  wire timer_setting_type             overcurrent_timing,
  input  wire logic [15:0]                   low_power_threshold,
  input  wire logic [15:0]                   output_power_reading,
  input  wire logic [13:0]                   overcurrent_threshold,
  input  wire logic [13:0]                   output_current_reading,
  input  wire logic [15:0]                   pump_rated_flow,
  input  wire logic [15:0]                   pumping_freq_reference,
  input  wire logic [15:0]                   output_frequency,
  input  wire logic [31:0]                   cumulative_saved_value,
  input  wire logic                          cumulative_clear_write,
  input  wire logic [7:0]                    tracking_step_setting,
  input  wire logic [9:0]                    start_ratio_setting,
  input  wire logic [7:0]                    fast_function_select,
  input  wire logic [11:0]                   open_circuit_voltage,
  input  wire logic [11:0]                   bus_voltage,
  input  wire logic [15:0]                   pv_power,
  input  wire logic [9:0]                    regulator_prop_gain,
  input  wire logic [6:0]                    regulator_int_gain,
  output alarm_type                          alarms,
  output logic                               power_alarm,
  output logic                               pump_stop,
  output logic [15:0]                        daily_volume_count,
  output logic [31:0]                        cumulative_volume_count,
  output logic                               cumulative_clear_request,
  output logic [15:0]                        present_flow_rate,
  output logic [11:0]                        bus_voltage_reference,
  output logic signed [15:0]                 current_command
);

  logic [19:0]             tick_cnt;
  logic                    tick;
  logic [19:0]             mppt_cnt;
  logic                    mppt_tick;
  logic [N_DI-1:0]         switch_hit;
  logic                    full_level_switch_input;
  logic                    analog_full;
  logic [2:0]              cond;
  logic [2:0]              cond_q;
  timer_setting_type [2:0] timing;
  logic [2:0][15:0]        tcnt;
  prot_state_type [2:0]    pstate;

  // Base 0.1 s tick and 2 ms tracking enable
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 20'(TICK_DIV - 1));
      tick_cnt <= (tick_cnt == 20'(TICK_DIV - 1)) ? '0 : tick_cnt + 20'h00001;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mppt_cnt  <= '0;
      mppt_tick <= 1'b0;
    end else begin
      mppt_tick <= (mppt_cnt == 20'(MPPT_DIV - 1));
      mppt_cnt  <= (mppt_cnt == 20'(MPPT_DIV - 1)) ? '0 : mppt_cnt + 20'h00001;
    end
  end

  // Any closed input carrying the full-water function, regardless of analog setup
  for (genvar i = 0; i < N_DI; i++) begin : g_di
    assign switch_hit[i] = di_closed[i] && (di_function[i] == FULL_SWITCH_FUNC);
  end
  assign full_level_switch_input = |switch_hit;

  // Analog level against threshold; the polarity digit flips the comparison
  always_comb begin
    logic [3:0] chan;
    logic [3:0] pol;
    analog_full = 1'b0;
    chan = full_level_channel_select[UNITS_LSB +: DIGIT_W];
    pol  = full_level_channel_select[TENS_LSB +: DIGIT_W];
    for (int k = 0; k < N_AI; k++) begin
      if (chan == 4'(k + 1)) begin
        if (pol == DIGIT_OFF) begin
          analog_full = analog_level[k] > full_level_threshold;
        end else begin
          analog_full = analog_level[k] < full_level_threshold;
        end
      end
    end
  end

  // Qualifying conditions; power and current count only while the pump runs
  assign cond[0] = full_level_switch_input || analog_full;
  assign cond[1] = running && (low_power_threshold != 16'h0000)
                   && (output_power_reading < low_power_threshold);
  assign cond[2] = running && (output_current_reading > overcurrent_threshold);
  assign timing  = {overcurrent_timing, low_power_timing, full_level_timing};

  // One detect/recover timer per protection
  for (genvar i = 0; i < 3; i++) begin : g_prot
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        cond_q[i] <= 1'b0;
        tcnt[i]   <= '0;
      end else begin
        cond_q[i] <= cond[i];
        if (cond[i] != cond_q[i]) begin
          tcnt[i] <= '0;
        end else if (tick && tcnt[i] != 16'hffff) begin
          tcnt[i] <= tcnt[i] + 16'h0001;
        end
      end
    end

    // Detect needs the full time held; recovery needs strictly longer than its time
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        pstate[i] <= PS_NORMAL;
      end else begin
        case (pstate[i])
          PS_NORMAL: if (cond[i] && cond_q[i] && tcnt[i] >= timing[i].detect_time) begin
            pstate[i] <= PS_ALARM;
          end
          PS_ALARM: if (!cond[i] && !cond_q[i] && tcnt[i] > timing[i].recover_time) begin
            pstate[i] <= PS_NORMAL;
          end
          default: pstate[i] <= PS_NORMAL;
        endcase
      end
    end
  end

  // Registered alarm outputs; both power faults share one alarm code
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alarms      <= '0;
      power_alarm <= 1'b0;
      pump_stop   <= 1'b0;
    end else begin
      alarms.full_water  <= pstate[0] == PS_ALARM;
      alarms.low_power   <= pstate[1] == PS_ALARM;
      alarms.overcurrent <= pstate[2] == PS_ALARM;
      power_alarm        <= (pstate[1] == PS_ALARM) || (pstate[2] == PS_ALARM);
      pump_stop          <= |pstate;
    end
  end

  // Flow estimate: rated * freq / reference, serial restoring divide
  logic [31:0] div_num;
  logic [31:0] div_quot;
  logic [16:0] div_rem;
  logic [4:0]  div_step;
  logic [16:0] rem_shift;
  logic        rem_fits;
  logic [31:0] div_final;

  assign rem_shift = {div_rem[15:0], div_num[31]};
  assign rem_fits  = rem_shift >= {1'b0, pumping_freq_reference};
  // The 32nd quotient bit is settled in the wrap cycle, so take it from there
  assign div_final = {div_quot[30:0], rem_fits};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_num           <= '0;
      div_quot          <= '0;
      div_rem           <= '0;
      div_step          <= '0;
      present_flow_rate <= '0;
    end else begin
      if (div_step == 5'h00) begin
        div_num <= pump_rated_flow * output_frequency;
        div_rem <= '0;
      end else begin
        div_num <= {div_num[30:0], 1'b0};
        div_rem <= rem_fits ? rem_shift - {1'b0, pumping_freq_reference} : rem_shift;
      end
      div_quot <= (div_step == 5'h00) ? '0 : {div_quot[30:0], rem_fits};
      div_step <= div_step + 5'h01;
      // A new quotient is complete every 32 cycles; saturate at 16 bits
      if (div_step == 5'h00) begin
        if (pumping_freq_reference == 16'h0000) begin
          present_flow_rate <= '0;
        end else begin
          present_flow_rate <= (div_final[31:16] != 16'h0000) ? 16'hffff : div_final[15:0];
        end
      end
    end
  end

  // Volume integration: one tenth per 36000 rate-ticks; at most one per tick
  logic [16:0] vol_acc;
  logic [3:0]  tenths;
  logic        loaded;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      vol_acc            <= '0;
      tenths             <= '0;
      daily_volume_count <= '0;
    end else if (tick) begin
      if (vol_acc + {1'b0, present_flow_rate} >= VOLUME_TICKS_PER_TENTH) begin
        vol_acc            <= 17'(vol_acc + {1'b0, present_flow_rate} - VOLUME_TICKS_PER_TENTH);
        daily_volume_count <= daily_volume_count + 16'h0001;
        tenths             <= (tenths == TENTHS_PER_M3 - 4'h1) ? '0 : tenths + 4'h1;
      end else begin
        vol_acc <= 17'(vol_acc + {1'b0, present_flow_rate});
      end
    end
  end

  // Cumulative counter: saved value taken after reset release; clear beats increment
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loaded                  <= 1'b0;
      cumulative_volume_count <= '0;
    end else if (!loaded) begin
      loaded                  <= 1'b1;
      cumulative_volume_count <= cumulative_saved_value;
    end else if (cumulative_clear_request) begin
      cumulative_volume_count <= '0;
    end else if (tick && tenths == TENTHS_PER_M3 - 4'h1
                 && vol_acc + {1'b0, present_flow_rate} >= VOLUME_TICKS_PER_TENTH) begin
      cumulative_volume_count <= cumulative_volume_count + 32'h00000001;
    end
  end

  // Clear request self-returns once served; a new write in that cycle wins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cumulative_clear_request <= 1'b0;
    end else if (cumulative_clear_write) begin
      cumulative_clear_request <= 1'b1;
    end else if (loaded) begin
      cumulative_clear_request <= 1'b0;
    end
  end

  // Tracker: start point, then perturb and observe on the 2 ms enable
  mppt_state_type mstate;
  logic [15:0]    last_power;
  logic           step_up;
  logic [11:0]    start_voltage;
  logic [11:0]    step_v;
  logic [21:0]    start_product;

  assign start_product = open_circuit_voltage * start_ratio_setting;
  assign start_voltage = 12'(start_product / UNIT_SCALE);
  // Fast tracking doubles the step: quicker convergence, coarser final point
  assign step_v = (fast_function_select[TENS_LSB +: DIGIT_W] != DIGIT_OFF)
                  ? {3'b000, tracking_step_setting, 1'b0}
                  : {4'h0, tracking_step_setting};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mstate                <= MP_IDLE;
      bus_voltage_reference <= VREF_RESET;
      last_power            <= '0;
      step_up               <= 1'b0;
    end else if (mppt_tick) begin
      case (mstate)
        MP_IDLE: begin
          bus_voltage_reference <= open_circuit_voltage;
          if (running) begin
            mstate <= MP_START;
          end
        end
        MP_START: begin
          if (!running) begin
            mstate <= MP_IDLE;
          end else if (fast_function_select[UNITS_LSB +: DIGIT_W] != DIGIT_OFF
                       || bus_voltage_reference <= start_voltage + step_v) begin
            bus_voltage_reference <= start_voltage;
            mstate                <= MP_TRACK;
          end else begin
            bus_voltage_reference <= bus_voltage_reference - step_v;
          end
        end
        MP_TRACK: begin
          last_power <= pv_power;
          if (!running) begin
            mstate <= MP_IDLE;
          end else begin
            // Reverse direction when power fell since the last sample
            if ((pv_power < last_power) ? !step_up : step_up) begin
              step_up               <= 1'b1;
              bus_voltage_reference <= (bus_voltage_reference > 12'hfff - step_v)
                                       ? 12'hfff : bus_voltage_reference + step_v;
            end else begin
              step_up               <= 1'b0;
              bus_voltage_reference <= (bus_voltage_reference < step_v)
                                       ? 12'h000 : bus_voltage_reference - step_v;
            end
          end
        end
        default: mstate <= MP_IDLE;
      endcase
    end
  end

  // PI voltage regulator, gains in thousandths; integrator clamped to avoid wind-up
  logic signed [12:0] v_err;
  logic signed [23:0] p_term;
  logic signed [23:0] i_acc;
  logic signed [23:0] i_next;
  logic signed [23:0] pi_sum;

  assign v_err  = $signed({1'b0, bus_voltage}) - $signed({1'b0, bus_voltage_reference});
  assign p_term = 24'(v_err * $signed({1'b0, regulator_prop_gain}));
  assign i_next = i_acc + 24'(v_err * $signed({1'b0, regulator_int_gain}));
  assign pi_sum = 24'((p_term + i_acc) / UNIT_SCALE);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      i_acc           <= '0;
      current_command <= '0;
    end else if (mppt_tick) begin
      if (mstate == MP_IDLE) begin
        i_acc <= '0;
      end else if (i_next < 24'sh7fffff / 2 && i_next > -(24'sh7fffff / 2)) begin
        i_acc <= i_next;
      end
      current_command <= (pi_sum > 24'sh007fff) ? 16'sh7fff
                       : (pi_sum < -24'sh008000) ? -16'sh8000 : 16'(pi_sum);
    end
  end

endmodule // pump_protection_supervisor

// ---- testbench/level_sensor_model.sv ----
`timescale 1ns/100ps
module level_sensor_model (
  input  wire logic             mclk,
  input  wire logic [9:0]       tank_level,
  input  wire logic [1:0]       probe_ch,
  input  wire logic             switch_closed,
  input  wire logic [2:0]       switch_port,
  input  wire logic [15:0]      power_now,
  input  wire logic [13:0]      current_now,
  output logic      [3:0][9:0]  analog_level,
  output logic      [5:0]       di_closed,
  output logic      [5:0][7:0]  di_function,
  output logic      [15:0]      output_power_reading,
  output logic      [13:0]      output_current_reading
);
  // Only the wired probe sees the tank; the rest read the mirror level, so a wrong pick flips the result
  always_ff @(posedge mclk) begin
    for (int k = 0; k < 4; k++) begin
      analog_level[k] <= (k == probe_ch) ? tank_level : 10'h3e8 - tank_level;
    end
  end
  // One switch carries the full-water code; the others carry a look-alike code and stay closed
  always_ff @(posedge mclk) begin
    for (int k = 0; k < 6; k++) begin
      di_function[k] <= (k == switch_port) ? 8'h3c : 8'h3d;
      di_closed[k]   <= (k == switch_port) ? switch_closed : 1'b1;
    end
  end
  // Meter readings lag one cycle, like a sampled measurement
  always_ff @(posedge mclk) begin
    output_power_reading   <= power_now;
    output_current_reading <= current_now;
  end
endmodule // level_sensor_model

// ---- testbench/pump_protection_supervisor_monitor.sv ----
`timescale 1ns/100ps
module supervisor_monitor import pump_supervisor_pkg::*; #(
  parameter int MPPT_DIV = MPPT_CYCLES
) (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [15:0] low_power_threshold,
  input wire logic        cumulative_clear_write,
  input wire alarm_type   alarms,
  input wire logic        power_alarm,
  input wire logic        pump_stop,
  input wire logic [15:0] daily_volume_count,
  input wire logic [31:0] cumulative_volume_count,
  input wire logic        cumulative_clear_request,
  input wire logic [11:0] bus_voltage_reference
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  int unsigned gap;
  logic        seen;
  // Cycles since the last reference change; the first change after reset is not timed
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap  <= 0;
      seen <= 1'b0;
    end else if ($changed(bus_voltage_reference)) begin
      gap  <= 0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end
  stop_on_full_a:
    assert property ($rose(alarms.full_water) |-> ##[0:1] pump_stop) else $error("pump kept running on full");
  shared_code_a:
    assert property ($rose(alarms.overcurrent) |-> ##[0:1] power_alarm) else $error("shared code missing");
  zero_threshold_a:
    assert property ((low_power_threshold == 16'h0000) [*4] |-> !$rose(alarms.low_power))
      else $error("disabled check fired");
  clear_taken_a:
    assert property (cumulative_clear_write |=> cumulative_clear_request) else $error("clear not taken");
  clear_self_a:
    assert property (cumulative_clear_request && !cumulative_clear_write |=> !cumulative_clear_request)
      else $error("no self return");
  clear_zero_a:
    assert property (cumulative_clear_request |=> cumulative_volume_count == 32'h0000_0000)
      else $error("count not cleared");
  daily_step_a:
    assert property ($changed(daily_volume_count) |-> daily_volume_count == $past(daily_volume_count) + 16'h0001)
      else $error("daily count jumped");
  track_period_a:
    assert property ($changed(bus_voltage_reference) && seen |-> gap >= MPPT_DIV - 1) else $error("tracker too fast");
  cover property ($rose(alarms.full_water));
  cover property ($rose(alarms.low_power));
  cover property ($rose(alarms.overcurrent));
  cover property (cumulative_clear_request);
endmodule // supervisor_monitor
bind pump_protection_supervisor supervisor_monitor #(.MPPT_DIV(MPPT_DIV)) MON (.mclk, .reset_n, .low_power_threshold,
  .cumulative_clear_write, .alarms, .power_alarm, .pump_stop, .daily_volume_count, .cumulative_volume_count,
  .cumulative_clear_request, .bus_voltage_reference);

// ---- testbench/test_pump_protection_supervisor.sv ----
`timescale 1ns/100ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_pump_protection_supervisor import pump_supervisor_pkg::*; ;
  logic                mclk = 1'b0, reset_n = 1'b0, running = 1'b0, cumulative_clear_write = 1'b0, sw_closed = 1'b0;
  logic [1:0]          probe_ch = 2'h0;
  logic [9:0]          tank = 10'h000, full_level_threshold = 10'h000, start_ratio_setting = 10'h1f4;
  logic [7:0]          full_level_channel_select = 8'h00, fast_function_select = 8'h00;
  logic [7:0]          tracking_step_setting = 8'h02;  // Left at its 2 V default
  timer_setting_type   full_level_timing = '0, low_power_timing = '0, overcurrent_timing = '0;
  logic [15:0]         low_power_threshold = 16'h0000, power_now = 16'h0000, pv_power = 16'h0100;
  logic [15:0]         pump_rated_flow = 16'h0000, pumping_freq_reference = 16'h07d0, output_frequency = 16'h07d0;
  logic [13:0]         overcurrent_threshold = 14'h3fff, current_now = 14'h0000;
  logic [31:0]         cumulative_saved_value = 32'h0000_1234;
  logic [11:0]         open_circuit_voltage = 12'h190, bus_voltage = 12'h180;
  logic [9:0]          regulator_prop_gain = 10'h032;
  logic [6:0]          regulator_int_gain = 7'h32;
  logic [5:0]          di_closed;
  logic [5:0][7:0]     di_function;
  logic [3:0][9:0]     analog_level;
  logic [15:0]         output_power_reading, daily_volume_count, present_flow_rate;
  logic [13:0]         output_current_reading;
  alarm_type           alarms;
  logic                power_alarm, pump_stop, cumulative_clear_request;
  logic [31:0]         cumulative_volume_count;
  logic [11:0]         bus_voltage_reference;
  logic signed [15:0]  current_command;
  int                  err_total = 0, n_compared = 0, n;

  pump_protection_supervisor #(.TICK_DIV(10), .MPPT_DIV(8)) DUT (.mclk, .reset_n, .running, .di_closed, .di_function,
    .analog_level, .full_level_channel_select, .full_level_threshold, .full_level_timing, .low_power_timing,
    .overcurrent_timing, .low_power_threshold, .output_power_reading, .overcurrent_threshold, .output_current_reading,
    .pump_rated_flow, .pumping_freq_reference, .output_frequency, .cumulative_saved_value, .cumulative_clear_write,
    .tracking_step_setting, .start_ratio_setting, .fast_function_select, .open_circuit_voltage, .bus_voltage,
    .pv_power, .regulator_prop_gain, .regulator_int_gain, .alarms, .power_alarm, .pump_stop, .daily_volume_count,
    .cumulative_volume_count, .cumulative_clear_request, .present_flow_rate, .bus_voltage_reference, .current_command);
  level_sensor_model MODEL (.mclk, .tank_level(tank), .probe_ch, .switch_closed(sw_closed), .switch_port(3'h3),
    .power_now, .current_now, .analog_level, .di_closed, .di_function, .output_power_reading, .output_current_reading);

  // Half period of 50 ns gives the 10 MHz system clock
  always #50 mclk = ~mclk;

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Inputs always move 10 ns after the edge, well clear of sampling
  task automatic tick(input int cycles);
    repeat (cycles) @(posedge mclk);
    #10;
  endtask
  task automatic give_up();
    err_total++;
    $display("mismatch at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  endtask
  task automatic wait_alarm(input int bit_i, input logic val, input int lim, output int cyc);
    cyc = 0;
    while (alarms[bit_i] !== val) begin
      if (cyc == lim) give_up();
      tick(1);
      cyc++;
    end
  endtask
  task automatic wait_vref();
    logic [11:0] prev;
    prev = bus_voltage_reference;
    for (int i = 0; bus_voltage_reference === prev; i++) begin
      if (i == 20) give_up();
      tick(1);
    end
  endtask
  // Power loss clears the daily count while the cumulative count comes back from storage
  task automatic do_reset();
    reset_n = 1'b0;
    tick(3);
    reset_n = 1'b1;
    tick(2);
    `CHECK(daily_volume_count, 16'h0000)
    `CHECK(cumulative_volume_count, 32'h0000_1234)
    `CHECK(alarms, 3'h0)
  endtask
  task automatic t_clear();
    cumulative_clear_write = 1'b1;
    tick(1);
    cumulative_clear_write = 1'b0;
    `CHECK(cumulative_clear_request, 1'b1)
    tick(1);
    `CHECK(cumulative_clear_request, 1'b0)
    `CHECK(cumulative_volume_count, 32'h0000_0000)
  endtask
  // A broken switch closure must restart the detect timer
  task automatic t_full_switch();
    full_level_timing = '{detect_time: 16'h0003, recover_time: 16'h0001};
    sw_closed = 1'b1;
    tick(18);
    `CHECK(alarms.full_water, 1'b0)
    sw_closed = 1'b0;
    tick(2);
    sw_closed = 1'b1;
    wait_alarm(0, 1'b1, 50, n);
    `CHECK(n >= 20, 1'b1)
    `CHECK(pump_stop, 1'b1)
    sw_closed = 1'b0;
    wait_alarm(0, 1'b0, 50, n);
    `CHECK(n >= 10, 1'b1)
  endtask
  task automatic t_full_analog();
    logic [7:0] sel [7] = '{8'h02, 8'h02, 8'h12, 8'h12, 8'h00, 8'h04, 8'h01};
    logic [9:0] lvl [7] = '{10'h258, 10'h190, 10'h190, 10'h258, 10'h258, 10'h258, 10'h1f4};
    logic       hit [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    full_level_timing = '0;
    full_level_threshold = 10'h1f4;
    for (int i = 0; i < 7; i++) begin
      probe_ch = sel[i][1:0] - 2'h1;
      tank = lvl[i];
      tick(2);
      full_level_channel_select = sel[i];
      if (hit[i]) wait_alarm(0, 1'b1, 12, n);
      else tick(30);
      `CHECK(alarms.full_water, hit[i])
      full_level_channel_select = 8'h00;
      wait_alarm(0, 1'b0, 30, n);
    end
  endtask
  task automatic t_power();
    running = 1'b1;
    low_power_timing = '{detect_time: 16'h0002, recover_time: 16'h0000};
    overcurrent_timing = '{detect_time: 16'h0001, recover_time: 16'h0000};
    low_power_threshold = 16'h0064;
    power_now = 16'h0032;
    wait_alarm(1, 1'b1, 45, n);
    `CHECK(n >= 10, 1'b1)
    `CHECK(power_alarm, 1'b1)
    power_now = 16'h00c8;
    wait_alarm(1, 1'b0, 30, n);
    low_power_threshold = 16'h0000;
    power_now = 16'h0032;
    tick(60);
    `CHECK(alarms.low_power, 1'b0)
    overcurrent_threshold = 14'h0064;
    current_now = 14'h00c8;
    wait_alarm(2, 1'b1, 35, n);
    `CHECK(power_alarm, 1'b1)
    running = 1'b0;
    wait_alarm(2, 1'b0, 30, n);
    current_now = 14'h0000;
  endtask
  // Slow start ramps by one step; fast start jumps straight to ratio times open-circuit voltage
  task automatic t_tracker();
    tick(20);
    `CHECK(bus_voltage_reference, 12'h190)
    // Idle holds the integrator at zero, so 1000 V of error at 0.05 gives 50
    bus_voltage = 12'h578;
    tick(20);
    `CHECK(current_command, 16'sh0032)
    bus_voltage = 12'h180;
    running = 1'b1;
    wait_vref();
    `CHECK(bus_voltage_reference, 12'h18e)
    running = 1'b0;
    fast_function_select = 8'h01;
    tick(20);
    running = 1'b1;
    wait_vref();
    `CHECK(bus_voltage_reference, 12'h0c8)
    running = 1'b0;
    // Fast tracking alone: slow start, but each step is doubled
    fast_function_select = 8'h10;
    tick(20);
    running = 1'b1;
    wait_vref();
    `CHECK(bus_voltage_reference, 12'h18c)
    running = 1'b0;
  endtask
  // At 3600 m3/h the daily count steps once a tick, so ten ticks make one cubic metre
  task automatic t_flow();
    pump_rated_flow = 16'h8ca0;
    for (int i = 0; daily_volume_count !== 16'h000a; i++) begin
      if (i == 400) give_up();
      tick(1);
    end
    tick(3);
    `CHECK(cumulative_volume_count, 32'h0000_0001)
    `CHECK(present_flow_rate, 16'h8ca0)
    do_reset();
    pump_rated_flow = 16'h0000;
  endtask

  initial begin
    do_reset();
    t_clear();
    t_full_switch();
    t_full_analog();
    t_power();
    t_tracker();
    t_flow();
    tally_and_finish();
  end
endmodule // test_pump_protection_supervisor
